// >>> iefs_stage.sv
// Purpose: Intermittent earth-fault stage with register port
// Assumes: Samples synchronous to clk; blocking input is a level
// Notes:   One evaluation per 5 ms program cycle, one clock after the tick
`include "iefs_defs.svh"
module iefs_stage #(
  parameter int TICK_CYC = `IEFS_TBASE_CYC
) (
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire logic [7:0]            reg_addr,
  input  wire logic [31:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [31:0]           reg_rdata,
  input  wire logic                  smp_valid,
  input  wire iefs_pkg::iefs_sample_s smp,
  input  wire logic                  blk_in,
  output logic                       forward_start,
  output logic                       reverse_start,
  output logic                       trip,
  output logic                       blocked,
  output logic                       display_event,
  output logic                       blk_event,
  output iefs_pkg::iefs_event_s      blk_event_data
);
  localparam int TCW = $clog2(TICK_CYC + 1);

  // Settings
  iefs_pkg::iefs_mode_e  mode_r, mode_nxt;
  iefs_pkg::iefs_force_e fcode_r, fcode_nxt;
  logic                  fen_r, fen_nxt;
  logic [1:0]            isel_r, isel_nxt, usel_r, usel_nxt;
  logic [15:0]           uthr_r, uthr_nxt, ithr_r, ithr_nxt;
  iefs_pkg::iefs_time_t  fwdrel_r, fwdrel_nxt, revrel_r, revrel_nxt, opdly_r, opdly_nxt;
  logic [7:0]            spkset_r, spkset_nxt;
  // Processing state
  logic [TCW-1:0]        tick_cnt_r, tick_cnt_nxt;
  logic                  tick, eval_r;
  logic                  blk_smp_r, blk_smp_nxt;
  logic                  fwd_r, fwd_nxt, rev_r, rev_nxt, trip_r, trip_nxt, blk_r, blk_nxt;
  iefs_pkg::iefs_time_t  op_cnt_r, op_cnt_nxt;
  logic [31:0]           spk_cnt_r, spk_cnt_nxt;
  // Outputs
  logic                  fwd_o_r, fwd_o_nxt, rev_o_r, rev_o_nxt, trip_o_r, trip_o_nxt, blk_o_r, blk_o_nxt;
  iefs_pkg::iefs_cond_e  cond_r, cond_nxt;
  logic                  evt_r, evt_nxt;
  iefs_pkg::iefs_event_s evd_r, evd_nxt;
  logic [31:0]           rdata_r, rdata_nxt;
  // Derived
  logic                  off, mode_blk, blk_eff, pick, spike, dir_fwd, fwd_spike, rev_spike;
  logic                  fwd_run, fwd_exp, rev_exp, op_done;
  logic [15:0]           u_peak, i_peak;
  logic                  u_neg, i_neg;
  logic signed [15:0]    i_sel_smp;
  iefs_pkg::iefs_time_t  t_rem;
  logic [31:0]           spk_rem;
  logic [1:0]            u_rep;

  // (RL3) Residual current channel select
  assign i_sel_smp = (isel_r == 2'h2) ? smp.i02 : smp.i01;

  // (RL23) Sample buffers for voltage and current
  iefs_peak_buf u_ubuf (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .clr      (off),
    .wr       (smp_valid),
    .din      (smp.u0),
    .peak     (u_peak),
    .peak_neg (u_neg)
  );
  iefs_peak_buf u_ibuf (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .clr      (off),
    .wr       (smp_valid),
    .din      (i_sel_smp),
    .peak     (i_peak),
    .peak_neg (i_neg)
  );

  // (RL19) Forward release timer
  iefs_rel_timer u_fwd_tmr (
    .clk     (clk),
    .sys_rst (sys_rst),
    .clr     (off),
    .tick    (tick),
    .restart (fwd_spike),
    .len     (fwdrel_r),
    .running (fwd_run),
    .expire  (fwd_exp)
  );
  // (RL20) Reverse release timer
  iefs_rel_timer u_rev_tmr (
    .clk     (clk),
    .sys_rst (sys_rst),
    .clr     (off),
    .tick    (tick),
    .restart (rev_spike),
    .len     (revrel_r),
    .running (),
    .expire  (rev_exp)
  );

  // Mode decode and pick-up
  assign off      = (mode_r == iefs_pkg::MODE_OFF);
  assign mode_blk = (mode_r == iefs_pkg::MODE_BLOCKED) || (mode_r == iefs_pkg::MODE_TEST_BLK);
  assign blk_eff  = blk_smp_r || mode_blk;
  // (RL5) Peak to threshold ratio above one
  assign pick     = (u_peak > uthr_r) && (i_peak > ithr_r);
  // (RL6) Start only unblocked above both
  assign spike    = eval_r && pick && !blk_eff && !off;
  assign dir_fwd  = u_neg ^ i_neg;
  assign fwd_spike = spike && dir_fwd;
  assign rev_spike = spike && !dir_fwd;
  assign op_done  = (op_cnt_r >= opdly_r);
  assign tick     = (tick_cnt_r == TCW'(TICK_CYC - 1));

  // Program cycle, blocking sample and protection state
  always_comb begin
    tick_cnt_nxt = tick ? '0 : tick_cnt_r + 1'b1;
    // (RL12) Blocking latched before evaluation
    blk_smp_nxt = tick ? blk_in : blk_smp_r;
    fwd_nxt     = fwd_r;
    rev_nxt     = rev_r;
    trip_nxt    = trip_r;
    blk_nxt     = blk_r;
    op_cnt_nxt  = op_cnt_r;
    spk_cnt_nxt = spk_cnt_r;
    // (RL21) Operating timer during forward start
    if (tick && fwd_run && fwd_r && !op_done) begin
      op_cnt_nxt = op_cnt_r + 1'b1;
    end
    // (RL13) Unblocked spike raises start
    if (fwd_spike) begin
      fwd_nxt = 1'b1;
      if (spk_cnt_r != 32'hffffffff) begin
        spk_cnt_nxt = spk_cnt_r + 32'h1;
      end
    end
    if (rev_spike) begin
      rev_nxt = 1'b1;
    end
    // (RL18) Definite time trip
    // (RL22) Spike count must exceed setting
    if (eval_r && fwd_r && !blk_eff && op_done && (spk_cnt_r > {24'h0, spkset_r})) begin
      trip_nxt = 1'b1;
    end
    // (RL14) Blocked pick-up only flags blocked
    if (eval_r) begin
      blk_nxt = blk_smp_r && (pick || blk_r);
    end
    // (RL15) Blocking drops start, timers run on
    if (eval_r && blk_eff) begin
      fwd_nxt  = 1'b0;
      rev_nxt  = 1'b0;
      trip_nxt = 1'b0;
    end
    // (RL19) Forward expiry releases stage
    if (fwd_exp) begin
      fwd_nxt     = 1'b0;
      trip_nxt    = 1'b0;
      op_cnt_nxt  = '0;
      spk_cnt_nxt = 32'h0;
    end
    // (RL20) Reverse expiry
    if (rev_exp) begin
      rev_nxt = 1'b0;
    end
    // (RL24) Blocked modes and Off
    if (mode_blk) begin
      blk_nxt = 1'b1;
    end
    if (off) begin
      fwd_nxt     = 1'b0;
      rev_nxt     = 1'b0;
      trip_nxt    = 1'b0;
      blk_nxt     = 1'b0;
      op_cnt_nxt  = '0;
      spk_cnt_nxt = 32'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tick_cnt_r <= '0;
      eval_r     <= 1'b0;
      blk_smp_r  <= 1'b0;
      fwd_r      <= 1'b0;
      rev_r      <= 1'b0;
      trip_r     <= 1'b0;
      blk_r      <= 1'b0;
      op_cnt_r   <= '0;
      spk_cnt_r  <= 32'h0;
    end else begin
      tick_cnt_r <= tick_cnt_nxt;
      eval_r     <= tick;
      blk_smp_r  <= blk_smp_nxt;
      fwd_r      <= fwd_nxt;
      rev_r      <= rev_nxt;
      trip_r     <= trip_nxt;
      blk_r      <= blk_nxt;
      op_cnt_r   <= op_cnt_nxt;
      spk_cnt_r  <= spk_cnt_nxt;
    end
  end

  // Readback values
  // (RL9) Time left while counting
  assign t_rem   = fwd_r ? (op_done ? '0 : opdly_r - op_cnt_r) : '0;
  // (RL11) Spikes still needed
  assign spk_rem = (spk_cnt_r <= {24'h0, spkset_r}) ? ({24'h0, spkset_r} + 32'h1 - spk_cnt_r) : 32'h0;
  // (RL8) Zero when no voltage channel
  assign u_rep   = (usel_r == 2'h1 || usel_r == 2'h2) ? usel_r : 2'h0;

  // Output stage with forcing and events
  always_comb begin
    fwd_o_nxt  = fwd_r;
    rev_o_nxt  = rev_r;
    trip_o_nxt = trip_r;
    blk_o_nxt  = blk_r;
    // (RL2) Forced status overrides outputs
    if (fen_r) begin
      fwd_o_nxt  = (fcode_r == iefs_pkg::FRC_FWD);
      rev_o_nxt  = (fcode_r == iefs_pkg::FRC_REV);
      trip_o_nxt = (fcode_r == iefs_pkg::FRC_TRIP);
      blk_o_nxt  = (fcode_r == iefs_pkg::FRC_BLOCKED);
    end
    // (RL7) Condition code
    if (trip_o_nxt) begin
      cond_nxt = iefs_pkg::COND_TRIP;
    end else if (fwd_o_nxt) begin
      cond_nxt = iefs_pkg::COND_FWD;
    end else if (rev_o_nxt) begin
      cond_nxt = iefs_pkg::COND_REV;
    end else if (blk_o_nxt) begin
      cond_nxt = iefs_pkg::COND_BLOCKED;
    end else begin
      cond_nxt = iefs_pkg::COND_NORMAL;
    end
    // (RL17) Event with startup values on blocking
    evt_nxt = blk_nxt && !blk_r;
    evd_nxt = evt_nxt ? '{u0_peak: u_peak, i0_peak: i_peak, fault_fwd: dir_fwd} : evd_r;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fwd_o_r  <= 1'b0;
      rev_o_r  <= 1'b0;
      trip_o_r <= 1'b0;
      blk_o_r  <= 1'b0;
      cond_r   <= iefs_pkg::COND_NORMAL;
      evt_r    <= 1'b0;
      evd_r    <= '0;
    end else begin
      fwd_o_r  <= fwd_o_nxt;
      rev_o_r  <= rev_o_nxt;
      trip_o_r <= trip_o_nxt;
      blk_o_r  <= blk_o_nxt;
      cond_r   <= cond_nxt;
      evt_r    <= evt_nxt;
      evd_r    <= evd_nxt;
    end
  end

  // Register writes and read mux
  always_comb begin
    mode_nxt   = mode_r;
    fen_nxt    = fen_r;
    fcode_nxt  = fcode_r;
    isel_nxt   = isel_r;
    usel_nxt   = usel_r;
    uthr_nxt   = uthr_r;
    ithr_nxt   = ithr_r;
    fwdrel_nxt = fwdrel_r;
    revrel_nxt = revrel_r;
    opdly_nxt  = opdly_r;
    spkset_nxt = spkset_r;
    if (reg_wr) begin
      case (reg_addr)
        // (RL1) Only codes one to five taken
        `IEFS_OFS_MODE: if (reg_wdata[2:0] >= 3'h1 && reg_wdata[2:0] <= 3'h5) begin
          mode_nxt = iefs_pkg::iefs_mode_e'(reg_wdata[2:0]);
        end
        `IEFS_OFS_FORCE: begin
          fen_nxt = reg_wdata[`IEFS_FRC_EN_BIT];
          if (reg_wdata[`IEFS_FRC_CODE_LO +: 3] <= 3'h4) begin
            fcode_nxt = iefs_pkg::iefs_force_e'(reg_wdata[`IEFS_FRC_CODE_LO +: 3]);
          end
        end
        `IEFS_OFS_CHSEL: begin
          if (reg_wdata[`IEFS_ISEL_LO +: 2] == 2'h1 || reg_wdata[`IEFS_ISEL_LO +: 2] == 2'h2) begin
            isel_nxt = reg_wdata[`IEFS_ISEL_LO +: 2];
          end
          usel_nxt = reg_wdata[`IEFS_USEL_LO +: 2];
        end
        // (RL4) Spike thresholds
        `IEFS_OFS_UTHR:   uthr_nxt   = reg_wdata[15:0];
        `IEFS_OFS_ITHR:   ithr_nxt   = reg_wdata[15:0];
        `IEFS_OFS_FWDREL: fwdrel_nxt = reg_wdata[`IEFS_TW-1:0];
        `IEFS_OFS_REVREL: revrel_nxt = reg_wdata[`IEFS_TW-1:0];
        `IEFS_OFS_OPDLY:  opdly_nxt  = reg_wdata[`IEFS_TW-1:0];
        `IEFS_OFS_SPKSET: spkset_nxt = reg_wdata[7:0];
        default: ;
      endcase
    end
    rdata_nxt = 32'h0;
    if (reg_rd) begin
      case (reg_addr)
        `IEFS_OFS_MODE:   rdata_nxt = {29'h0, mode_r};
        `IEFS_OFS_FORCE:  rdata_nxt = {25'h0, fcode_r, 3'h0, fen_r};
        `IEFS_OFS_CHSEL:  rdata_nxt = {26'h0, usel_r, 2'h0, isel_r};
        `IEFS_OFS_UTHR:   rdata_nxt = {16'h0, uthr_r};
        `IEFS_OFS_ITHR:   rdata_nxt = {16'h0, ithr_r};
        `IEFS_OFS_FWDREL: rdata_nxt = {12'h0, fwdrel_r};
        `IEFS_OFS_REVREL: rdata_nxt = {12'h0, revrel_r};
        `IEFS_OFS_OPDLY:  rdata_nxt = {12'h0, opdly_r};
        `IEFS_OFS_SPKSET: rdata_nxt = {24'h0, spkset_r};
        `IEFS_OFS_STATUS: rdata_nxt = {20'h0, pick, blk_smp_r, u_rep, blk_o_r, trip_o_r, rev_o_r, fwd_o_r,
                                       1'b0, cond_r};
        `IEFS_OFS_TREM:   rdata_nxt = {12'h0, t_rem};
        // (RL10) Expected operating time
        `IEFS_OFS_EXPOP:  rdata_nxt = {12'h0, opdly_r};
        `IEFS_OFS_SPKREM: rdata_nxt = spk_rem;
        `IEFS_OFS_SPKCNT: rdata_nxt = spk_cnt_r;
        default:          rdata_nxt = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mode_r   <= iefs_pkg::iefs_mode_e'(`IEFS_RST_MODE);
      fen_r    <= 1'b0;
      fcode_r  <= iefs_pkg::FRC_NORMAL;
      isel_r   <= `IEFS_RST_ISEL;
      usel_r   <= `IEFS_RST_USEL;
      uthr_r   <= `IEFS_RST_UTHR;
      ithr_r   <= `IEFS_RST_ITHR;
      fwdrel_r <= `IEFS_RST_FWDREL;
      revrel_r <= `IEFS_RST_REVREL;
      opdly_r  <= `IEFS_RST_OPDLY;
      spkset_r <= `IEFS_RST_SPKSET;
      rdata_r  <= 32'h0;
    end else begin
      mode_r   <= mode_nxt;
      fen_r    <= fen_nxt;
      fcode_r  <= fcode_nxt;
      isel_r   <= isel_nxt;
      usel_r   <= usel_nxt;
      uthr_r   <= uthr_nxt;
      ithr_r   <= ithr_nxt;
      fwdrel_r <= fwdrel_nxt;
      revrel_r <= revrel_nxt;
      opdly_r  <= opdly_nxt;
      spkset_r <= spkset_nxt;
      rdata_r  <= rdata_nxt;
    end
  end

  assign reg_rdata      = rdata_r;
  assign forward_start  = fwd_o_r;
  assign reverse_start  = rev_o_r;
  assign trip           = trip_o_r;
  assign blocked        = blk_o_r;
  assign display_event  = evt_r;
  assign blk_event      = evt_r;
  assign blk_event_data = evd_r;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_fwd_spike;
    fwd_spike && !off;
  endsequence
  sequence s_blocked_pick;
    eval_r && blk_smp_r && pick && !off;
  endsequence

  a_blk_sampled: assert property (tick |=> blk_smp_r == $past(blk_in)) // RL12
    else $error("blocking input not sampled at tick");
  a_spike_starts: assert property (s_fwd_spike |=> fwd_r && op_cnt_r == $past(op_cnt_r)) // RL13
    else $error("forward spike did not raise start");
  a_blk_pick_only: assert property (s_blocked_pick |=> blk_r && !fwd_r && !rev_r ##1 blk_o_r || fen_r) // RL14
    else $error("blocked pick-up did not flag blocked");
  a_blk_drop_start: assert property (eval_r && blk_eff |=> !fwd_r && !rev_r && !trip_r) // RL15
    else $error("start kept while blocked");
  a_fwd_release: assert property (fwd_exp |=> !fwd_r && op_cnt_r == '0 && spk_cnt_r == 32'h0) // RL19
    else $error("forward expiry did not release");
  a_rev_release: assert property (rev_exp && !rev_spike |=> !rev_r) // RL20
    else $error("reverse expiry did not clear start");
  a_op_counts: assert property (tick && fwd_run && fwd_r && !op_done && !fwd_exp && !off
                                |=> op_cnt_r == $past(op_cnt_r) + 1'b1) // RL21
    else $error("operating timer did not advance");
  a_trip_spikes: assert property ($rose(trip_r) |-> $past(spk_cnt_r) > {24'h0, $past(spkset_r)}) // RL22
    else $error("trip without enough spikes");
  a_off_quiet: assert property (off |=> !fwd_r && !rev_r && !trip_r && !blk_r && spk_cnt_r == 32'h0) // RL24
    else $error("off mode left state active");
  a_force_trip: assert property (fen_r && fcode_r == iefs_pkg::FRC_TRIP |=> trip && !forward_start) // RL2
    else $error("forced trip not shown");
  a_cond_trip: assert property (trip_o_r |-> cond_r == iefs_pkg::COND_TRIP) // RL7
    else $error("condition code disagrees with trip");
  a_blk_event: assert property ($rose(blk_r) |-> blk_event && display_event ##1 !blk_event) // RL17
    else $error("blocking event missing");
endmodule // iefs_stage

// >>> iefs_defs.svh
// Purpose: Constants of the intermittent earth-fault stage
// Assumes: 25 MHz clk, one processing step per 5 ms time base
// Notes:   Offsets are byte addresses on the plain register port
// How it works
// (RL1) Mode On/Blocked/Test/TestBlocked/Off, default On
// (RL2) Forcing overrides outputs, five codes, default normal
// (RL3) Current channel select, code one default
// (RL4) Voltage and current spike thresholds with defaults
// (RL5) Compare thresholds with buffer maxima every cycle
// (RL6) Start needs no blocking, both thresholds exceeded
// (RL7) Read-only condition code zero to four
// (RL8) Report voltage channel, zero when none
// (RL9) Time remaining to trip, 5 ms steps
// (RL10) Expected operating time readable, 5 ms steps
// (RL11) Spikes remaining to trip, 32-bit count
// (RL12) Blocking input sampled before pick-up evaluation
// (RL13) Unblocked pick-up raises start, runs timing
// (RL14) Blocked pick-up raises blocked, nothing more
// (RL15) Blocking drops start, release timing continues
// (RL16) Blocking source leads operate delay by 5 ms
// (RL17) Blocking emits display and stamped event
// (RL18) Definite time trip while pick-up stays
// (RL19) Forward release timer restarts per forward spike
// (RL20) Reverse release timer restarts per reverse spike
// (RL21) Operating timer runs during forward start
// (RL22) Trip only when spike count exceeds setting
// (RL23) Inputs are circular sample buffers, 5 ms
// (RL24) Off clears all; blocked modes assert blocked
`ifndef IEFS_DEFS_SVH
`define IEFS_DEFS_SVH

// Timing
`define IEFS_CLK_NS       40
`define IEFS_TBASE_NS     5000000
`define IEFS_TBASE_CYC    (`IEFS_TBASE_NS / `IEFS_CLK_NS)
`define IEFS_TW           20
`define IEFS_BUF_DEPTH    8

// Register offsets
`define IEFS_OFS_MODE     8'h00
`define IEFS_OFS_FORCE    8'h04
`define IEFS_OFS_CHSEL    8'h08
`define IEFS_OFS_UTHR     8'h0c
`define IEFS_OFS_ITHR     8'h10
`define IEFS_OFS_FWDREL   8'h14
`define IEFS_OFS_REVREL   8'h18
`define IEFS_OFS_OPDLY    8'h1c
`define IEFS_OFS_SPKSET   8'h20
`define IEFS_OFS_STATUS   8'h24
`define IEFS_OFS_TREM     8'h28
`define IEFS_OFS_EXPOP    8'h2c
`define IEFS_OFS_SPKREM   8'h30
`define IEFS_OFS_SPKCNT   8'h34

// Field positions
`define IEFS_FRC_EN_BIT   0
`define IEFS_FRC_CODE_LO  4
`define IEFS_ISEL_LO      0
`define IEFS_USEL_LO      4

// Reset values
`define IEFS_RST_MODE     3'h1
`define IEFS_RST_ISEL     2'h1
`define IEFS_RST_USEL     2'h1
`define IEFS_RST_UTHR     16'h1f40
`define IEFS_RST_ITHR     16'h0032
`define IEFS_RST_FWDREL   20'h0003c
`define IEFS_RST_REVREL   20'h0003c
`define IEFS_RST_OPDLY    20'h00064
`define IEFS_RST_SPKSET   8'h02

`endif

// >>> iefs_pkg.sv
// Purpose: Types shared by the earth-fault stage files
// Assumes: iefs_defs.svh gives the widths
// Notes:   Codes match the documented setting values
`include "iefs_defs.svh"
package iefs_pkg;
  typedef enum logic [2:0] {
    MODE_ON = 3'h1, MODE_BLOCKED = 3'h2, MODE_TEST = 3'h3, MODE_TEST_BLK = 3'h4, MODE_OFF = 3'h5
  } iefs_mode_e;
  typedef enum logic [2:0] {
    FRC_NORMAL = 3'h0, FRC_BLOCKED = 3'h1, FRC_FWD = 3'h2, FRC_REV = 3'h3, FRC_TRIP = 3'h4
  } iefs_force_e;
  typedef enum logic [2:0] {
    COND_NORMAL = 3'h0, COND_FWD = 3'h1, COND_REV = 3'h2, COND_TRIP = 3'h3, COND_BLOCKED = 3'h4
  } iefs_cond_e;
  typedef logic [`IEFS_TW-1:0] iefs_time_t;
  typedef struct packed {
    logic signed [15:0] u0;
    logic signed [15:0] i01;
    logic signed [15:0] i02;
  } iefs_sample_s;
  typedef struct packed {
    logic [15:0] u0_peak;
    logic [15:0] i0_peak;
    logic        fault_fwd;
  } iefs_event_s;
endpackage : iefs_pkg

// >>> iefs_peak_buf.sv
// Purpose: Circular sample buffer with registered peak magnitude
// Assumes: wr pulses once per new per-unit sample
// Notes:   Peak sign shows the polarity of the largest sample
`include "iefs_defs.svh"
module iefs_peak_buf #(
  parameter int DEPTH = `IEFS_BUF_DEPTH
) (
  input  wire logic               clk,
  input  wire logic               sys_rst,
  input  wire logic               clr,
  input  wire logic               wr,
  input  wire logic signed [15:0] din,
  output logic             [15:0] peak,
  output logic                    peak_neg
);
  localparam int IW = $clog2(DEPTH);
  logic signed [15:0] mem_r   [DEPTH];
  logic signed [15:0] mem_nxt [DEPTH];
  logic [IW-1:0]      idx_r, idx_nxt;
  logic [15:0]        peak_r, peak_nxt;
  logic               neg_r, neg_nxt;

  function automatic logic [15:0] mag(input logic signed [15:0] x);
    mag = x[15] ? 16'(-x) : 16'(x);
  endfunction

  // (RL23) Circular write and maximum search
  always_comb begin
    mem_nxt  = mem_r;
    idx_nxt  = idx_r;
    peak_nxt = 16'h0000;
    neg_nxt  = 1'b0;
    for (int k = 0; k < DEPTH; k++) begin
      if (mag(mem_r[k]) > peak_nxt) begin
        peak_nxt = mag(mem_r[k]);
        neg_nxt  = mem_r[k][15];
      end
    end
    if (clr) begin
      for (int k = 0; k < DEPTH; k++) begin
        mem_nxt[k] = 16'sh0000;
      end
      idx_nxt = '0;
    end else if (wr) begin
      mem_nxt[idx_r] = din;
      idx_nxt = (idx_r == IW'(DEPTH - 1)) ? '0 : idx_r + 1'b1;
    end
  end

  // Registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int k = 0; k < DEPTH; k++) begin
        mem_r[k] <= 16'sh0000;
      end
      idx_r  <= '0;
      peak_r <= 16'h0000;
      neg_r  <= 1'b0;
    end else begin
      mem_r  <= mem_nxt;
      idx_r  <= idx_nxt;
      peak_r <= peak_nxt;
      neg_r  <= neg_nxt;
    end
  end

  assign peak     = peak_r;
  assign peak_neg = neg_r;
endmodule // iefs_peak_buf

// >>> iefs_rel_timer.sv
// Purpose: Restartable down-counting release timer in time-base ticks
// Assumes: tick pulses once per 5 ms
// Notes:   expire is a one-cycle pulse on the last tick
`include "iefs_defs.svh"
module iefs_rel_timer (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              clr,
  input  wire logic              tick,
  input  wire logic              restart,
  input  wire iefs_pkg::iefs_time_t len,
  output logic                   running,
  output logic                   expire
);
  iefs_pkg::iefs_time_t cnt_r, cnt_nxt;

  // Reload on spike, count down on tick
  always_comb begin
    cnt_nxt = cnt_r;
    if (clr) begin
      cnt_nxt = '0;
    end else if (restart) begin
      cnt_nxt = len;
    end else if (tick && cnt_r != '0) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign running = (cnt_r != '0);
  assign expire  = tick && !clr && !restart && (cnt_r == iefs_pkg::iefs_time_t'(1));
endmodule // iefs_rel_timer

// >>> iefs_meas_model.sv
// Purpose: Residual measurement chain and blocking source model
// Assumes: New sample set every 4 clocks, per-unit values
// Notes:   Bench sets fault presence, direction and blocking
module iefs_meas_model (
  input  wire logic              clk,
  input  wire logic              fault,
  input  wire logic              fwd,
  input  wire logic              blk_req,
  output logic                   smp_valid,
  output iefs_pkg::iefs_sample_s smp,
  output logic                   blk_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] div_r;
  // Quiet line at time zero, then one update per rising edge
  initial begin
    div_r = 2'h0;
    smp_valid = 1'b0;
    smp = '0;
    blk_in = 1'b0;
    forever begin
      @(posedge clk);
      div_r <= div_r + 2'h1;
      smp_valid <= (div_r == 2'h3);
      smp.u0 <= fault ? 16'sh2710 : 16'sh0000;
      smp.i01 <= fault ? (fwd ? -16'sh00c8 : 16'sh00c8) : 16'sh0000;
      smp.i02 <= 16'sh0000;
      blk_in <= blk_req;
    end
  end
endmodule // iefs_meas_model

// >>> testbench.sv
// Purpose: Self-checking bench of the earth-fault stage
// Assumes: Tick shortened to 20 clocks
// Notes:   Register port driven by tasks, samples by the model
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic fault = 1'b0, fwd = 1'b1, blk_req = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, rd_val, reg_rdata;
  logic smp_valid, blk_in, forward_start, reverse_start, trip, blocked, display_event, blk_event;
  iefs_pkg::iefs_sample_s smp;
  iefs_pkg::iefs_event_s blk_event_data;
  int bad_count = 0, checked = 0, blk_pulses = 0;
  logic [7:0] ra[13] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h2c, 8'h30, 8'h3c};
  logic [31:0] rv[13] = '{32'h1, 32'h0, 32'h11, 32'h1f40, 32'h32, 32'h3c, 32'h3c, 32'h64, 32'h2, 32'h100,
                          32'h64, 32'h3, 32'h0};
  iefs_stage #(.TICK_CYC(20)) iefs_stage_inst (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .smp_valid(smp_valid),
    .smp(smp), .blk_in(blk_in), .forward_start(forward_start), .reverse_start(reverse_start), .trip(trip),
    .blocked(blocked), .display_event(display_event), .blk_event(blk_event), .blk_event_data(blk_event_data));
  iefs_meas_model iefs_meas_model_inst (.clk(clk), .fault(fault), .fwd(fwd), .blk_req(blk_req),
    .smp_valid(smp_valid), .smp(smp), .blk_in(blk_in));
  // Clock and event pulse count
  always #20 clk = ~clk;
  always @(posedge clk) begin
    if (blk_event === 1'b1 && display_event === 1'b1) blk_pulses++;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    rd_val = reg_rdata;
    @(posedge clk);
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // Poll at falling edges, hand back control on a rising edge
  task automatic wait_for(ref logic s, input logic v, input int n, input string nm);
    int k;
    k = 0;
    @(negedge clk);
    while (k < n && s !== v) begin
      @(negedge clk);
      k++;
    end
    chk(nm, {31'h0, v}, {31'h0, s});
    @(posedge clk);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Watchdog
  initial begin
    #(40 * 20000);
    bad_count++;
    results();
  end
  // Test sequence
  initial begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    for (int k = 0; k < 13; k++) begin
      rd(ra[k]);
      chk("reset value", rv[k], rd_val);
    end
    $display("reset values done");
    wr(8'h14, 32'h4);
    wr(8'h18, 32'h4);
    wr(8'h1c, 32'h6);
    fault <= 1'b1;
    wait_for(forward_start, 1'b1, 100, "forward_start");
    chk("reverse_start", 32'h0, {31'h0, reverse_start});
    wait_for(trip, 1'b1, 300, "trip");
    rd(8'h30);
    chk("spikes remaining", 32'h0, rd_val);
    fault <= 1'b0;
    wait_for(forward_start, 1'b0, 600, "forward release");
    chk("trip release", 32'h0, {31'h0, trip});
    $display("forward fault done");
    wr(8'h00, 32'h3);
    fwd <= 1'b0;
    fault <= 1'b1;
    wait_for(reverse_start, 1'b1, 100, "reverse_start");
    chk("forward_start", 32'h0, {31'h0, forward_start});
    fault <= 1'b0;
    wait_for(reverse_start, 1'b0, 600, "reverse release");
    $display("reverse fault done");
    fwd <= 1'b1;
    fault <= 1'b1;
    wait_for(forward_start, 1'b1, 100, "forward_start");
    blk_req <= 1'b1;
    wait_for(blocked, 1'b1, 100, "blocked");
    repeat (2) @(posedge clk);
    chk("start dropped", 32'h0, {31'h0, forward_start});
    chk("block events", 32'h1, blk_pulses);
    chk("event voltage", 32'h2710, {16'h0, blk_event_data.u0_peak});
    chk("event current", 32'h191, {15'h0, blk_event_data.i0_peak, blk_event_data.fault_fwd});
    rd(8'h24);
    chk("condition", 32'h4, {29'h0, rd_val[2:0]});
    blk_req <= 1'b0;
    fault <= 1'b0;
    wait_for(blocked, 1'b0, 100, "unblocked");
    $display("blocking done");
    wr(8'h00, 32'h5);
    fault <= 1'b1;
    repeat (200) @(posedge clk);
    chk("off outputs", 32'h0, {28'h0, forward_start, reverse_start, trip, blocked});
    fault <= 1'b0;
    wr(8'h00, 32'h1);
    $display("off mode done");
    wr(8'h08, 32'h02);
    rd(8'h24);
    chk("voltage channel", 32'h0, {30'h0, rd_val[9:8]});
    fault <= 1'b1;
    repeat (60) @(posedge clk);
    chk("channel b starts", 32'h0, {30'h0, forward_start, reverse_start});
    fault <= 1'b0;
    wr(8'h08, 32'h11);
    wr(8'h00, 32'h2);
    repeat (3) @(posedge clk);
    chk("blocked mode", 32'h1, {31'h0, blocked});
    wr(8'h00, 32'h1);
    $display("channel and blocked mode done");
    for (int c = 1; c < 5; c++) begin
      wr(8'h04, 32'h1 | (c << 4));
      repeat (3) @(posedge clk);
      chk("forced outputs", 32'h1 << (c - 1), {28'h0, trip, reverse_start, forward_start, blocked});
    end
    wr(8'h04, 32'h0);
    $display("forcing done");
    results();
  end
endmodule // testbench
